// File: rtl/eoa_overhead_access.sv
// e1 double-frame overhead access: apb registers, rx capture, tx overhead sourcing
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns

// Contract
// - receive registers hold raw received overhead bits
// - both receive registers update on align boundary
// - status bit 0 set on receive refresh
// - transmit registers sampled when status bit 3 sets
// - stale transmit registers are simply retransmitted
// - si from overhead, per-frame registers, or serial
// - receive align byte: pattern 0-6, si 7
// - receive non-align: sa8-4, alarm, nfas, si
// - transmit align byte: pattern 0-6, si 7
// - transmit non-align: sa8-4, alarm, nfas, si
// - align insert enable takes per-frame si bits
module eoa_overhead_access import eoa_pkg::*; #(
  parameter int ADDR_W = 8 // apb address width
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer receive stream
  input wire logic rx_frame_strobe,
  input wire logic rx_align_mark,
  input wire logic [7:0] rx_ts0_byte,
  // framer transmit stream
  input wire logic tx_frame_strobe,
  input wire logic tx_align_mark,
  input wire logic serial_transmit_data_input,
  output logic [7:0] tx_ts0_byte,
  output logic tx_ts0_valid,
  // interrupt
  output logic irq
);

  // ==========================================================================
  // elaboration checks
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 6 and 32");
  end

  // ==========================================================================
  // declarations
  eoa_state_t s_reg; // all block state except the receive capture, which lives in u_rx
  eoa_state_t s_next; // its next value
  logic [7:0] rx_raf; // published align byte from capture
  logic [7:0] rx_rx_nonalign_frame_overhead; // published non-align byte from capture
  logic rx_upd; // receive refresh pulse
  logic acc; // apb access phase
  logic wr; // apb write takes effect
  logic hit; // address is mapped
  logic [7:0] addr8; // low address byte
  logic tx_is_af; // current tx frame is an align frame
  logic [2:0] tx_idx; // double-frame index that this tx frame belongs to
  logic [3:0] st_set; // hardware events this cycle
  logic [7:0] af_src; // align byte source for this frame
  logic si_bit; // chosen international bit

  // ==========================================================================
  // address decode, used by both read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      ADDR_RX_AF, ADDR_RX_NAF, ADDR_TX_AF, ADDR_TX_NAF, ADDR_CTRL,
      ADDR_PF_AF, ADDR_PF_NAF, ADDR_STATUS, ADDR_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // si chosen per frame type; insertion from per-frame registers wins
  function automatic logic pick_si(input logic ins, input logic pass, input logic pf_bit,
                                   input logic ser, input logic oh_bit);
    if (ins) begin
      pick_si = pf_bit;
    end else if (pass) begin
      pick_si = ser;
    end else begin
      pick_si = oh_bit;
    end
  endfunction : pick_si

  // ==========================================================================
  // receive capture
  eoa_rx_capture u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .frame_strobe(rx_frame_strobe),
    .align_mark(rx_align_mark),
    .ts0_byte(rx_ts0_byte),
    .rx_align_frame_overhead(rx_raf),
    .rx_nonalign_frame_overhead(rx_rx_nonalign_frame_overhead),
    .upd(rx_upd)
  );

  // ==========================================================================
  // apb handshake: zero wait states, errors on unmapped words
  assign addr8 = paddr[7:0];
  assign hit = addr_mapped(addr8) && (paddr[ADDR_W-1:0] >> 8) == '0;
  assign acc = psel & penable;
  assign wr = acc & pwrite & hit;
  assign pready = 1'b1; // every access completes in its first access cycle
  assign pslverr = acc & ~hit;

  // read mux straight from flops; narrow fields sit in the low bits
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (addr8)
        ADDR_RX_AF: prdata = {24'h00_0000, rx_raf};
        ADDR_RX_NAF: prdata = {24'h00_0000, rx_rx_nonalign_frame_overhead};
        ADDR_TX_AF: prdata = {24'h00_0000, s_reg.tx_align_frame_overhead};
        ADDR_TX_NAF: prdata = {24'h00_0000, s_reg.tx_nonalign_frame_overhead};
        ADDR_CTRL: prdata = {29'h0, s_reg.ctrl};
        ADDR_PF_AF: prdata = {24'h00_0000, s_reg.pf_af};
        ADDR_PF_NAF: prdata = {24'h00_0000, s_reg.pf_naf};
        ADDR_STATUS: prdata = {28'h000_0000, s_reg.status};
        ADDR_MASK: prdata = {28'h000_0000, s_reg.mask};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // transmit framing helpers
  // the framer mark re-anchors the alternation, otherwise frames toggle
  assign tx_is_af = tx_align_mark | ~s_reg.tx_phase_naf;
  // a marked frame is frame 0, so it must not use the index left over from before the mark
  assign tx_idx = tx_align_mark ? 3'd0 : s_reg.dbl_idx;
  // on an align frame the byte goes out from what is being sampled right now
  assign af_src = s_reg.tx_align_frame_overhead;
  assign si_bit = tx_is_af
    ? pick_si(s_reg.ctrl[CTRL_SI_AF_BIT], s_reg.ctrl[CTRL_SI_PASS_BIT],
              s_reg.pf_af[3'd7 - tx_idx], serial_transmit_data_input,
              af_src[OH_SI_BIT])
    : pick_si(s_reg.ctrl[CTRL_SI_NAF_BIT], s_reg.ctrl[CTRL_SI_PASS_BIT],
              s_reg.pf_naf[3'd7 - tx_idx], serial_transmit_data_input,
              s_reg.sh_naf[OH_SI_BIT]);

  // events that set status bits this cycle
  always_comb begin
    st_set = 4'h0;
    st_set[ST_RX_AF_BIT] = rx_upd;
    // refresh while the last one is still flagged: host missed its window
    st_set[ST_RX_OVR_BIT] = rx_upd & s_reg.status[ST_RX_AF_BIT];
    st_set[ST_TX_AF_BIT] = tx_frame_strobe & tx_is_af;
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.tx_valid = 1'b0;

    // register writes from software
    if (wr) begin
      case (addr8)
        ADDR_TX_AF: s_next.tx_align_frame_overhead = pwdata[7:0];
        ADDR_TX_NAF: s_next.tx_nonalign_frame_overhead = pwdata[7:0];
        ADDR_CTRL: s_next.ctrl = pwdata[2:0];
        ADDR_PF_AF: s_next.pf_af = pwdata[7:0];
        ADDR_PF_NAF: s_next.pf_naf = pwdata[7:0];
        ADDR_MASK: s_next.mask = pwdata[3:0] & STATUS_USED;
        default: s_next.mask = s_reg.mask;
      endcase
    end

    // sticky status: write one clears, a same-cycle event wins
    s_next.status = s_reg.status;
    if (wr && addr8 == ADDR_STATUS) begin
      s_next.status = s_reg.status & ~pwdata[3:0];
    end
    s_next.status = (s_next.status | st_set) & STATUS_USED;

    // transmit overhead sourcing
    if (tx_frame_strobe) begin
      s_next.tx_phase_naf = tx_is_af;
      s_next.tx_valid = 1'b1;
      if (tx_is_af) begin
        // sample both registers together; unwritten ones go out again
        s_next.sh_af = s_reg.tx_align_frame_overhead;
        s_next.sh_naf = s_reg.tx_nonalign_frame_overhead;
        s_next.tx_byte = {si_bit, af_src[6:0]};
      end else begin
        s_next.tx_byte = {si_bit, s_reg.sh_naf[6:0]};
        // double-frame index steps after the non-align half
        s_next.dbl_idx = s_reg.dbl_idx + 3'd1;
      end
      // a mark restarts the multiframe count for per-frame si
      if (tx_align_mark) begin
        s_next.dbl_idx = 3'd0;
      end
    end
  end

  // ==========================================================================
  // state register; reset loads the default patterns, which software writes can replace at any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.tx_align_frame_overhead <= RST_TX_AF;
      s_reg.tx_nonalign_frame_overhead <= RST_TX_NAF;
      s_reg.ctrl <= RST_CTRL;
      s_reg.pf_af <= RST_ZERO;
      s_reg.pf_naf <= RST_ZERO;
      s_reg.status <= RST_STATUS;
      s_reg.mask <= RST_STATUS;
      s_reg.tx_phase_naf <= 1'b0;
      s_reg.dbl_idx <= 3'd0;
      s_reg.sh_af <= RST_TX_AF;
      s_reg.sh_naf <= RST_TX_NAF;
      s_reg.tx_byte <= RST_ZERO;
      s_reg.tx_valid <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs
  assign tx_ts0_byte = s_reg.tx_byte;
  assign tx_ts0_valid = s_reg.tx_valid;
  // level interrupt while any unmasked status bit is set
  assign irq = |(s_reg.status & s_reg.mask);

  // ==========================================================================
  // checks
  property p_rx_flag;
    @(posedge pclk) disable iff (!presetn)
      rx_upd |=> s_reg.status[ST_RX_AF_BIT];
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("rx flag not set on refresh");

  property p_rx_hold;
    @(posedge pclk) disable iff (!presetn)
      !rx_upd |-> ($stable(rx_raf) && $stable(rx_rx_nonalign_frame_overhead));
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx registers moved off boundary");

  property p_tx_sample;
    @(posedge pclk) disable iff (!presetn)
      (tx_frame_strobe && tx_is_af) |=>
        ({s_reg.sh_af, s_reg.sh_naf} == $past({s_reg.tx_align_frame_overhead, s_reg.tx_nonalign_frame_overhead}) && s_reg.status[ST_TX_AF_BIT]);
  endproperty
  a_tx_sample: assert property (p_tx_sample) else $error("tx not sampled with flag");

  property p_tx_retransmit;
    @(posedge pclk) disable iff (!presetn)
      !(tx_frame_strobe && tx_is_af) |=> $stable(s_reg.sh_naf);
  endproperty
  a_tx_retransmit: assert property (p_tx_retransmit) else $error("tx shadow changed");

  property p_si_align_insert;
    @(posedge pclk) disable iff (!presetn)
      (tx_frame_strobe && tx_is_af && s_reg.ctrl[CTRL_SI_AF_BIT]) |=>
        (tx_ts0_valid && tx_ts0_byte[OH_SI_BIT] == $past(s_reg.pf_af[3'd7 - tx_idx]));
  endproperty
  a_si_align_insert: assert property (p_si_align_insert) else $error("align si source");

  property p_si_pass;
    @(posedge pclk) disable iff (!presetn)
      (tx_frame_strobe && !tx_is_af && !s_reg.ctrl[CTRL_SI_NAF_BIT]
       && s_reg.ctrl[CTRL_SI_PASS_BIT]) |=>
        tx_ts0_byte[OH_SI_BIT] == $past(serial_transmit_data_input);
  endproperty
  a_si_pass: assert property (p_si_pass) else $error("si pass-through wrong");

  property p_tx_naf_byte;
    @(posedge pclk) disable iff (!presetn)
      (tx_frame_strobe && !tx_is_af) |=>
        (tx_ts0_byte[6:0] == $past(s_reg.sh_naf[6:0]) && !s_reg.tx_phase_naf);
  endproperty
  a_tx_naf_byte: assert property (p_tx_naf_byte) else $error("tx nonalign byte wrong");

  property p_tx_af_byte;
    @(posedge pclk) disable iff (!presetn)
      (tx_frame_strobe && tx_is_af) |=>
        (tx_ts0_byte[6:0] == $past(s_reg.tx_align_frame_overhead[6:0]) && s_reg.tx_phase_naf);
  endproperty
  a_tx_af_byte: assert property (p_tx_af_byte) else $error("tx align byte wrong");

  property p_w1c_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (rx_upd && wr && addr8 == ADDR_STATUS && pwdata[ST_RX_AF_BIT]) |=>
        s_reg.status[ST_RX_AF_BIT];
  endproperty
  a_w1c_set_wins: assert property (p_w1c_set_wins) else $error("rx event lost in clear");

endmodule : eoa_overhead_access

// File: common/eoa_pkg.sv
// package of constants and state carriers for the e1 double-frame overhead access block
package eoa_pkg;

  // ==========================================================================
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_RX_AF = 8'h00; // rx_align_frame_overhead, read only
  localparam logic [7:0] ADDR_RX_NAF = 8'h04; // rx_nonalign_frame_overhead, read only
  localparam logic [7:0] ADDR_TX_AF = 8'h08; // tx_align_frame_overhead
  localparam logic [7:0] ADDR_TX_NAF = 8'h0c; // tx_nonalign_frame_overhead
  localparam logic [7:0] ADDR_CTRL = 8'h10; // international bit source control
  localparam logic [7:0] ADDR_PF_AF = 8'h14; // tx_per_frame_intl_align
  localparam logic [7:0] ADDR_PF_NAF = 8'h18; // tx_per_frame_intl_nonalign
  localparam logic [7:0] ADDR_STATUS = 8'h1c; // status_register_four, write one to clear
  localparam logic [7:0] ADDR_MASK = 8'h20; // interrupt mask, same layout as status

  // ==========================================================================
  // field positions
  localparam int CTRL_SI_AF_BIT = 0; // intl_align_insert_enable
  localparam int CTRL_SI_NAF_BIT = 1; // intl_nonalign_insert_enable
  localparam int CTRL_SI_PASS_BIT = 2; // take si from the serial transmit data input
  localparam int ST_RX_AF_BIT = 0; // receive overhead registers refreshed
  localparam int ST_RX_OVR_BIT = 2; // refresh came while the previous one was still flagged
  localparam int ST_TX_AF_BIT = 3; // transmit overhead registers sampled
  localparam int OH_SI_BIT = 7; // international bit in both overhead bytes
  localparam int OH_NFAS_BIT = 6; // nonalignment bit in the non-align byte
  localparam int OH_RA_BIT = 5; // remote alarm in the non-align byte

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_TX_AF = 8'h1b; // alignment pattern 1,1,0,1,1,0,0 from bit 0
  localparam logic [7:0] RST_TX_NAF = 8'h40; // nonalignment bit one, rest zero
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [3:0] STATUS_USED = 4'hd; // bits that exist in the status register

  // ==========================================================================
  // timing: host service window after a status flag
  localparam int HOST_WINDOW_US = 250;
  localparam int CLK_MHZ = 100;
  localparam int HOST_WINDOW_CYC = HOST_WINDOW_US * CLK_MHZ;

  // ==========================================================================
  // state carriers
  typedef struct packed {
    logic phase_naf; // next frame expected is a non-align frame
    logic pair_ok; // hold_af and hold_naf belong to one double-frame
    logic [7:0] hold_af; // align byte of the double-frame in progress
    logic [7:0] hold_naf; // non-align byte of the double-frame in progress
    logic [7:0] rx_align_frame_overhead; // published align byte
    logic [7:0] rx_nonalign_frame_overhead; // published non-align byte
    logic upd; // one-cycle refresh pulse
  } eoa_rx_state_t;

  typedef struct packed {
    logic [7:0] tx_align_frame_overhead; // tx_align_frame_overhead
    logic [7:0] tx_nonalign_frame_overhead; // tx_nonalign_frame_overhead
    logic [2:0] ctrl; // si source control
    logic [7:0] pf_af; // per-frame si, align frames
    logic [7:0] pf_naf; // per-frame si, non-align frames
    logic [3:0] status; // status_register_four
    logic [3:0] mask; // interrupt mask
    logic tx_phase_naf; // next tx frame is a non-align frame
    logic [2:0] dbl_idx; // double-frame index within the multiframe
    logic [7:0] sh_af; // sampled align byte in flight
    logic [7:0] sh_naf; // sampled non-align byte in flight
    logic [7:0] tx_byte; // time-slot-0 byte to the framer
    logic tx_valid; // one-cycle strobe with tx_byte
  } eoa_state_t;

endpackage : eoa_pkg

// File: rtl/eoa_rx_capture.sv
// receive side double-frame capture of the time-slot-0 overhead bytes
`timescale 1ns/1ns
module eoa_rx_capture import eoa_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // framer receive stream
  input wire logic frame_strobe,
  input wire logic align_mark,
  input wire logic [7:0] ts0_byte,
  // published overhead
  output logic [7:0] rx_align_frame_overhead,
  output logic [7:0] rx_nonalign_frame_overhead,
  output logic upd
);

  eoa_rx_state_t s_reg; // all capture state
  eoa_rx_state_t s_next; // its next value
  logic is_af; // the current frame is an align frame

  // ==========================================================================
  // capture and publish
  // frames alternate; a mark from the framer re-anchors the alternation
  assign is_af = align_mark | ~s_reg.phase_naf;

  always_comb begin
    s_next = s_reg;
    s_next.upd = 1'b0;
    if (frame_strobe) begin
      s_next.phase_naf = is_af; // toggle to the other frame type
      if (is_af) begin
        // publish the whole pair only on an align boundary
        if (s_reg.pair_ok) begin
          s_next.rx_align_frame_overhead = s_reg.hold_af; // raw received bits, no insertion applied
          s_next.rx_nonalign_frame_overhead = s_reg.hold_naf;
          s_next.upd = 1'b1;
        end
        s_next.hold_af = ts0_byte;
        s_next.pair_ok = 1'b0;
      end else begin
        s_next.hold_naf = ts0_byte;
        s_next.pair_ok = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rx_align_frame_overhead = s_reg.rx_align_frame_overhead;
  assign rx_nonalign_frame_overhead = s_reg.rx_nonalign_frame_overhead;
  assign upd = s_reg.upd;

  // ==========================================================================
  // checks
  property p_rx_pair_publish;
    @(posedge pclk) disable iff (!presetn)
      (frame_strobe && is_af && s_reg.pair_ok) |=>
        (upd && rx_align_frame_overhead == $past(s_reg.hold_af) && rx_nonalign_frame_overhead == $past(s_reg.hold_naf));
  endproperty
  a_rx_pair_publish: assert property (p_rx_pair_publish) else $error("rx pair not published");

  property p_rx_naf_capture;
    @(posedge pclk) disable iff (!presetn)
      (frame_strobe && !is_af) |=> (s_reg.hold_naf == $past(ts0_byte) && !upd);
  endproperty
  a_rx_naf_capture: assert property (p_rx_naf_capture) else $error("rx nonalign byte lost");

endmodule : eoa_rx_capture

// File: dv/eoa_framer_model.sv
// framer stream model: sources receive overhead bytes and requests transmit bytes
`timescale 1ns/1ns
module eoa_framer_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // receive stream towards the block
  output logic rx_frame_strobe,
  output logic rx_align_mark,
  output logic [7:0] rx_ts0_byte,
  // transmit stream
  output logic tx_frame_strobe,
  output logic tx_align_mark,
  output logic serial_transmit_data_input,
  input wire logic [7:0] tx_ts0_byte,
  input wire logic tx_ts0_valid
);
  logic [7:0] last_tx; // last byte handed over with the valid strobe

  // ==========================================================================
  // idle levels at time zero
  initial begin
    rx_frame_strobe = 1'b0;
    rx_align_mark = 1'b0;
    rx_ts0_byte = 8'h00;
    tx_frame_strobe = 1'b0;
    tx_align_mark = 1'b0;
    serial_transmit_data_input = 1'b0;
    last_tx = 8'h00;
  end

  // capture the transmit byte only in its one valid cycle
  always @(posedge pclk) begin
    if (tx_ts0_valid === 1'b1) begin
      last_tx <= tx_ts0_byte;
    end
  end

  // one received frame; byte line shows the inverse once the strobe is gone
  task automatic send_rx(input logic align, input logic [7:0] b);
    @(posedge pclk);
    rx_frame_strobe <= 1'b1;
    rx_align_mark <= align; // align and non-align frames alternate
    rx_ts0_byte <= b;
    @(posedge pclk);
    rx_frame_strobe <= 1'b0;
    rx_align_mark <= 1'b0;
    rx_ts0_byte <= ~b;
    repeat (3) @(posedge pclk);
  endtask : send_rx

  // one transmit request; serial bit valid with the strobe only
  task automatic send_tx(input logic align, input logic ser);
    @(posedge pclk);
    tx_frame_strobe <= 1'b1;
    tx_align_mark <= align;
    serial_transmit_data_input <= ser;
    @(posedge pclk);
    tx_frame_strobe <= 1'b0;
    tx_align_mark <= 1'b0;
    serial_transmit_data_input <= ~ser;
    repeat (3) @(posedge pclk);
  endtask : send_tx
endmodule : eoa_framer_model

// File: dv/e1_double_frame_overhead_access_tb.sv
// self-checking testbench for the double-frame overhead access block
`timescale 1ns/1ns
module e1_double_frame_overhead_access_tb import eoa_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_frame_strobe, rx_align_mark, tx_frame_strobe, tx_align_mark, ser;
  logic [7:0] rx_ts0_byte, tx_ts0_byte;
  logic tx_ts0_valid;
  logic irq;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rd; // last read data
  logic er; // last error response

  // ==========================================================================
  // clock, 100 mhz
  always #5 pclk = ~pclk;

  eoa_overhead_access #(.ADDR_W(8)) u_eoa_overhead_access (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_strobe(rx_frame_strobe), .rx_align_mark(rx_align_mark),
    .rx_ts0_byte(rx_ts0_byte), .tx_frame_strobe(tx_frame_strobe),
    .tx_align_mark(tx_align_mark), .serial_transmit_data_input(ser),
    .tx_ts0_byte(tx_ts0_byte), .tx_ts0_valid(tx_ts0_valid), .irq(irq));

  eoa_framer_model u_eoa_framer_model (
    .pclk(pclk), .presetn(presetn), .rx_frame_strobe(rx_frame_strobe),
    .rx_align_mark(rx_align_mark), .rx_ts0_byte(rx_ts0_byte),
    .tx_frame_strobe(tx_frame_strobe), .tx_align_mark(tx_align_mark),
    .serial_transmit_data_input(ser), .tx_ts0_byte(tx_ts0_byte),
    .tx_ts0_valid(tx_ts0_valid));

  // ==========================================================================
  // comparison and verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // apb transfer; waits for pready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    // the slave answers in its first access cycle
    chk("apb access cycles", n, 32'd1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read one register and compare its value
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rchk

  // transmit one frame and compare the byte handed to the framer
  task automatic tchk(input logic al, input logic s, input logic [7:0] exp);
    u_eoa_framer_model.send_tx(al, s);
    chk("tx_ts0_byte", {24'h0, u_eoa_framer_model.last_tx}, {24'h0, exp});
  endtask : tchk

  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused accesses
    rchk("rx_align", ADDR_RX_AF, 32'h0);
    rchk("rx_nonalign", ADDR_RX_NAF, 32'h0);
    rchk("tx_align", ADDR_TX_AF, 32'h1b);
    rchk("tx_nonalign", ADDR_TX_NAF, 32'h40);
    rchk("status", ADDR_STATUS, 32'h0);
    rchk("unmapped", 8'h24, 32'h0);
    chk("pslverr", {31'h0, er}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h1);
    // lone align frame and a half pair publish nothing
    u_eoa_framer_model.send_rx(1'b1, 8'h9b);
    u_eoa_framer_model.send_rx(1'b0, 8'h7d);
    rchk("status", ADDR_STATUS, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    // next align boundary publishes the pair as received
    u_eoa_framer_model.send_rx(1'b1, 8'h1b);
    rchk("rx_align", ADDR_RX_AF, 32'h9b);
    rchk("rx_nonalign", ADDR_RX_NAF, 32'h7d);
    rchk("status", ADDR_STATUS, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_RX_AF, 32'h55);
    chk("pslverr", {31'h0, er}, 32'h0);
    rchk("rx_align", ADDR_RX_AF, 32'h9b);
    apb(1'b1, ADDR_STATUS, 32'h1);
    rchk("status", ADDR_STATUS, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    // two refreshes without clearing status bit 0: older pair lost, overrun flagged
    u_eoa_framer_model.send_rx(1'b0, 8'h40);
    u_eoa_framer_model.send_rx(1'b1, 8'h9b);
    rchk("rx_nonalign", ADDR_RX_NAF, 32'h40);
    u_eoa_framer_model.send_rx(1'b0, 8'h41);
    u_eoa_framer_model.send_rx(1'b1, 8'h1b);
    rchk("rx_align", ADDR_RX_AF, 32'h9b);
    rchk("rx_nonalign", ADDR_RX_NAF, 32'h41);
    rchk("status", ADDR_STATUS, 32'h5);
    apb(1'b1, ADDR_STATUS, 32'h5);
    // transmit registers sampled at the align strobe
    apb(1'b1, ADDR_TX_AF, 32'h9b);
    apb(1'b1, ADDR_TX_NAF, 32'h75);
    tchk(1'b1, 1'b0, 8'h9b);
    rchk("status", ADDR_STATUS, 32'h8);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_TX_NAF, 32'h60);
    tchk(1'b0, 1'b0, 8'h75);
    tchk(1'b1, 1'b0, 8'h9b);
    tchk(1'b0, 1'b0, 8'h60);
    // international bit sources
    apb(1'b1, ADDR_PF_AF, 32'h7f);
    apb(1'b1, ADDR_CTRL, 32'h1);
    tchk(1'b1, 1'b1, 8'h1b);
    apb(1'b1, ADDR_CTRL, 32'h4);
    tchk(1'b0, 1'b1, 8'he0);
    tchk(1'b1, 1'b0, 8'h1b);
    apb(1'b1, ADDR_PF_NAF, 32'h80);
    apb(1'b1, ADDR_CTRL, 32'h2);
    tchk(1'b1, 1'b0, 8'h9b);
    tchk(1'b0, 1'b0, 8'he0);
    wrap_up();
  end
endmodule : e1_double_frame_overhead_access_tb
